// ### flash_array_model.sv
// behavioural flash array answering erase and write commands
// assumes the sequencer's command carrier on the same clock
`timescale 1ns/1ns

module flash_array_model (
	input  wire logic                    ref_clk,
	input  wire logic                    reset_n,
	input  flash_spm_pkg::flash_cmd_type flash_cmd,
	input  wire logic [7:0]              done_delay,
	output logic                         flash_done
);
	import flash_spm_pkg::*;
	logic [7:0] cnt_q;
	logic       run_q;

	// ==========================================================
	// array timer; lock commands get no completion pulse at all
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 8'h00;
			run_q <= 1'b0;
			flash_done <= 1'b0;
		end else begin
			flash_done <= 1'b0;
			if (flash_cmd.valid && flash_cmd.op inside {CMD_ERASE, CMD_WRITE}) begin
				run_q <= 1'b1;
				cnt_q <= done_delay;
			end else if (run_q && cnt_q == 8'h00) begin
				run_q <= 1'b0;
				flash_done <= 1'b1;
			end else if (run_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule

// ### flash_self_program_control.sv
// flash self-program sequencer: control register, store/load windows,
// temporary page buffer, busy and halt tracking, fuse/lock readback
// assumes cpu core, eeprom and flash back end all run on ref_clk; fuse
// and lock inputs are static nonvolatile levels from the same chip
//
// Contract
// R1: reset fetch address chosen by boot fuse
// R2: cpu never alters fuses; no write path
// R3: control resets zero, bit5 zero, bit6 read-only
// R4: ready request while enabled and store-enable clear
// R5: busy flag set on section op, blocks reads
// R6: buffer load clears busy flag
// R7: reenable clears busy, ignored while op running
// R8: reenable write discards loaded buffer data
// R9: lock set programs from r0, then clears
// R10: load in three cycles returns lock/fuse
// R11: page write from buffer to z page
// R12: page erase of z page, then clears
// R13: halt cpu for protected section operations
// R14: plain store puts r1:r0 in buffer word
// R15: store-enable window four clocks, held during op
// R16: only five low patterns arm anything
// R17: target page latched at operation start
// R18: low z bits word, high bits page
// R19: software erases with page-only z pointer
// R20: software erases before write, same page
// R21: buffer words writable in any order
// R22: byte reads use full z including z0
// R23: buffer cleared by write, reenable, reset; once
// R24: eeprom busy blocks programming and readback
// R25: z 1 lock, 0 fuse low, 3 high
// R26: windows counted from control write cycle

`timescale 1ns/1ns

module flash_self_program_control (
	input  wire logic                          ref_clk,
	input  wire logic                          reset_n,
	input  flash_spm_pkg::reg_req_type         reg_req,
	output logic [7:0]                         reg_rd_data,
	input  wire logic                          spm_exec,
	input  wire logic                          lpm_exec,
	input  wire logic [15:0]                   z_ptr,
	input  wire logic [15:0]                   r1r0_data,
	input  wire logic                          global_irq_enable,
	input  wire logic                          eeprom_busy,
	input  wire logic                          boot_reset_fuse,
	input  wire logic [7:0]                    fuse_low,
	input  wire logic [7:0]                    fuse_high,
	input  wire logic [7:0]                    lock_bits,
	output flash_spm_pkg::flash_cmd_type       flash_cmd,
	input  wire logic                          flash_done,
	input  wire logic [5:0]                    buf_rd_index,
	output logic [15:0]                        buf_rd_data,
	output flash_spm_pkg::read_req_type        read_req,
	output logic                               lpm_valid,
	output logic [7:0]                         lpm_data,
	output logic [15:0]                        reset_vector,
	output logic                               cpu_halt,
	output logic                               section_read_block,
	output logic                               ready_irq
);
	import flash_spm_pkg::*;

	// ==========================================================
	// state record
	typedef struct packed {
		seq_state_type                   state;
		logic [2:0]                      win_cnt;
		logic                            ready_irq_enable;
		logic                            section_busy_flag;
		logic [4:0]                      ctrl_low;
		logic [PAGE_WORDS-1:0]           buf_valid;
		logic [PAGE_WORDS-1:0][15:0]     buf_data;
		logic [15:0]                     buf_rd_data;
		flash_cmd_type                   flash_cmd;
		read_req_type                    read_req;
		logic                            lpm_valid;
		logic [7:0]                      lpm_data;
		logic                            vector_taken;
		logic [15:0]                     reset_vector;
		logic                            cpu_halt;
		logic                            ready_irq;
		logic [7:0]                      rd_data;
	} ctl_state_type;

	logic          rst_meta_n;
	logic          rst_n;
	ctl_state_type s_q;
	ctl_state_type s_d;

	// ==========================================================
	// reset release
	// async assert, release after two edges so no flop leaves reset early
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// ==========================================================
	// next-state helpers
	function automatic logic legal_pattern(input logic [4:0] p);
		legal_pattern = (p == PAT_REENABLE) || (p == PAT_LOCK) ||
			(p == PAT_WRITE) || (p == PAT_ERASE) ||
			(p == PAT_LOAD);
	endfunction

	function automatic logic [7:0] readback(input logic [15:0] z,
		input logic [7:0] fl, input logic [7:0] fh, input logic [7:0] lk);
		// other z values fall back on z0 alone: 1 lock, 0 fuse low
		if (z == Z_FUSE_HIGH)
			readback = fh;
		else if (z == Z_LOCK)
			readback = lk;
		else if (z == Z_FUSE_LOW)
			readback = fl;
		else
			readback = z[0] ? lk : fl;
	endfunction

	// ==========================================================
	// sequencer
	always_comb begin
		logic                 spm_ok;
		logic                 lpm_rb;
		logic                 reg_wr_ok;
		logic [WORD_BITS-1:0] widx;
		logic [PAGE_BITS-1:0] pg;
		s_d       = s_q;
		spm_ok    = 1'b0;
		lpm_rb    = 1'b0;
		reg_wr_ok = 1'b0;
		widx      = z_ptr[WORD_MSB:WORD_LSB]; // see R18 see R14
		pg        = z_ptr[PAGE_MSB:PAGE_LSB]; // see R18

		// single-cycle outputs fall back each cycle
		s_d.flash_cmd.valid = 1'b0;
		s_d.read_req.valid  = 1'b0;
		s_d.lpm_valid       = 1'b0;
		s_d.rd_data         = 8'h00;

		// boot fuse caught once, after reset release
		if (!s_q.vector_taken) begin
			s_d.vector_taken = 1'b1;
			s_d.reset_vector = boot_reset_fuse ? APP_RESET_ADDR :
				BOOT_RESET_ADDR; // see R1
		end

		// eeprom writes freeze both instruction paths
		spm_ok = (s_q.state == ST_ARMED) && spm_exec &&
			!eeprom_busy; // see R24
		lpm_rb = (s_q.state == ST_ARMED) && (s_q.ctrl_low == PAT_LOCK) &&
			(s_q.win_cnt > LOAD_MIN_CNT) && lpm_exec &&
			!eeprom_busy; // see R10 see R24 see R26

		unique case (s_q.state)
			ST_IDLE: begin
				s_d.win_cnt = 3'h0;
			end
			ST_ARMED: begin
				if (spm_ok) begin
					s_d.ctrl_low = PAT_NONE; // see R15
					s_d.state    = ST_IDLE;
					unique case (s_q.ctrl_low)
						PAT_LOAD: begin
							// write-once words; order is free
							if (!s_q.buf_valid[widx]) begin // see R23 see R21
								s_d.buf_valid[widx] = 1'b1;
								s_d.buf_data[widx]  = r1r0_data; // see R14
							end
							s_d.section_busy_flag = 1'b0; // see R6
						end
						PAT_REENABLE: begin
							s_d.section_busy_flag = 1'b0; // see R7
							s_d.buf_valid = '0; // see R23
						end
						PAT_LOCK: begin
							// r0 zeros in bits 5..2 program lock bits; r1 and z ignored
							s_d.flash_cmd.valid     = 1'b1;
							s_d.flash_cmd.op        = CMD_LOCK;
							s_d.flash_cmd.lock_data = lock_bits &
								(r1r0_data[7:0] | ~LOCK_R0_MASK); // see R9
						end
						default: begin
							// erase or write: page latched, z free again
							s_d.flash_cmd.valid = 1'b1;
							s_d.flash_cmd.op    = (s_q.ctrl_low == PAT_WRITE) ?
								CMD_WRITE : CMD_ERASE; // see R11 see R12
							s_d.flash_cmd.page  = pg; // see R17
							s_d.ctrl_low        = s_q.ctrl_low; // see R15
							s_d.state           = ST_BUSY;
							if (pg >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
								s_d.cpu_halt = 1'b1; // see R13
							else
								s_d.section_busy_flag = 1'b1; // see R5
						end
					endcase
				end else if (lpm_rb) begin
					s_d.lpm_valid = 1'b1;
					s_d.lpm_data  = readback(z_ptr, fuse_low, fuse_high,
						lock_bits); // see R25 see R10
					s_d.ctrl_low  = PAT_NONE;
					s_d.state     = ST_IDLE;
				end else if (s_q.win_cnt == 3'h1) begin
					// window ran out with no instruction
					s_d.ctrl_low = PAT_NONE; // see R15 see R9
					s_d.state    = ST_IDLE;
					s_d.win_cnt  = 3'h0;
				end else begin
					s_d.win_cnt = s_q.win_cnt - 3'h1; // see R26
				end
			end
			ST_BUSY: begin
				// store-enable and op bit held until the array finishes
				if (flash_done) begin
					s_d.ctrl_low = PAT_NONE; // see R15 see R11 see R12
					s_d.cpu_halt = 1'b0; // see R13
					s_d.state    = ST_IDLE;
					if (s_q.ctrl_low == PAT_WRITE)
						s_d.buf_valid = '0; // see R23
				end
			end
			default: begin
				s_d.state    = ST_IDLE;
				s_d.ctrl_low = PAT_NONE;
			end
		endcase

		// ordinary program reads: full byte address, z0 picks the byte
		if (lpm_exec && !lpm_rb && !eeprom_busy) begin
			if (!(s_q.section_busy_flag &&
				(z_ptr[PAGE_MSB:PAGE_LSB] < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE))) begin // see R5
				s_d.read_req.valid = 1'b1;
				s_d.read_req.addr  = z_ptr; // see R22
			end
		end

		// register write; an instruction taken this cycle wins over it
		reg_wr_ok = reg_req.wr && (reg_req.addr == CTRL_OFFSET) &&
			!spm_ok && !lpm_rb;
		if (reg_wr_ok) begin
			s_d.ready_irq_enable = reg_req.wdata[IRQ_EN_POS];
			// busy flag and reserved bit are never written
			if ((s_q.state != ST_BUSY) && !eeprom_busy &&
				legal_pattern(reg_req.wdata[4:0])) begin // see R16 see R7
				s_d.ctrl_low = reg_req.wdata[4:0];
				s_d.win_cnt  = STORE_WIN_CLKS; // see R26
				s_d.state    = ST_ARMED;
				if (reg_req.wdata[REENABLE_POS])
					s_d.buf_valid = '0; // see R8
			end
		end

		// register read, answered in the next cycle
		if (reg_req.rd && (reg_req.addr == CTRL_OFFSET)) begin
			s_d.rd_data = {s_q.ready_irq_enable, s_q.section_busy_flag,
				1'b0, s_q.ctrl_low}; // see R3
		end

		// ready request is a level, not a pulse
		s_d.ready_irq = s_q.ready_irq_enable && global_irq_enable &&
			!s_q.ctrl_low[STORE_EN_POS]; // see R4

		// back end reads the buffer; unloaded words read erased
		s_d.buf_rd_data = s_q.buf_valid[buf_rd_index] ?
			s_q.buf_data[buf_rd_index] : ERASED_WORD;
	end

	// ==========================================================
	// state register
	// fuse inputs go nowhere but readback and the vector mux: no writer
	always_ff @(posedge ref_clk or negedge rst_n) begin // see R2
		if (!rst_n) begin
			s_q                   <= '0;
			s_q.state             <= ST_IDLE;
			s_q.ctrl_low          <= CTRL_RESET[4:0]; // see R3
			s_q.flash_cmd.op      <= CMD_NONE;
			s_q.reset_vector      <= APP_RESET_ADDR;
			s_q.buf_valid         <= '0; // see R23
			s_q.buf_rd_data       <= ERASED_WORD;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs, each straight from the state record
	assign reg_rd_data        = s_q.rd_data;
	assign flash_cmd          = s_q.flash_cmd;
	assign buf_rd_data        = s_q.buf_rd_data;
	assign read_req           = s_q.read_req;
	assign lpm_valid          = s_q.lpm_valid;
	assign lpm_data           = s_q.lpm_data;
	assign reset_vector       = s_q.reset_vector;
	assign cpu_halt           = s_q.cpu_halt;
	assign section_read_block = s_q.section_busy_flag; // see R5
	assign ready_irq          = s_q.ready_irq;

endmodule

// ### flash_self_program_control_assertions.sv
// concurrent checks on the self-program sequencer's ports
// assumes one clock domain and the package types of the design
`timescale 1ns/1ns

module flash_self_program_control_assertions (
	input  wire logic                    ref_clk,
	input  wire logic                    reset_n,
	input  flash_spm_pkg::reg_req_type   reg_req,
	input  wire logic [7:0]              reg_rd_data,
	input  wire logic                    spm_exec,
	input  wire logic                    lpm_exec,
	input  wire logic [15:0]             z_ptr,
	input  wire logic                    eeprom_busy,
	input  wire logic                    boot_reset_fuse,
	input  flash_spm_pkg::flash_cmd_type flash_cmd,
	input  wire logic                    flash_done,
	input  flash_spm_pkg::read_req_type  read_req,
	input  wire logic                    lpm_valid,
	input  wire logic                    cpu_halt,
	input  wire logic [15:0]             reset_vector
);
	import flash_spm_pkg::*;
	logic [7:0] z_page;

	// page field of the pointer, kept apart so $past sees a plain signal
	assign z_page = z_ptr[14:7];

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// register, command and readback relations
	property p_rsv_zero;
		reg_req.rd |=> reg_rd_data[5] == 1'b0;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved bit set");
	property p_cmd_cause;
		flash_cmd.valid |-> $past(spm_exec) && !$past(eeprom_busy);
	endproperty
	a_cmd_cause: assert property (p_cmd_cause)
		else $error("stray command");
	property p_cmd_page;
		flash_cmd.valid && flash_cmd.op != CMD_LOCK
			|-> flash_cmd.page == $past(z_page);
	endproperty
	a_cmd_page: assert property (p_cmd_page)
		else $error("page field wrong");
	property p_halt_no_read_while_write_section;
		$rose(cpu_halt) |-> flash_cmd.page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
	endproperty
	a_halt_no_read_while_write_section: assert property (p_halt_no_read_while_write_section)
		else $error("halt on rww page");
	property p_halt_hold;
		cpu_halt && !flash_done |=> cpu_halt;
	endproperty
	a_halt_hold: assert property (p_halt_hold)
		else $error("halt dropped early");
	property p_eeprom_block;
		eeprom_busy |=> !flash_cmd.valid && !lpm_valid;
	endproperty
	a_eeprom_block: assert property (p_eeprom_block)
		else $error("eeprom not blocking");
	property p_lpm_cause;
		lpm_valid |-> $past(lpm_exec);
	endproperty
	a_lpm_cause: assert property (p_lpm_cause)
		else $error("stray readback");
	property p_read_addr;
		read_req.valid |-> $past(lpm_exec) &&
			read_req.addr == $past(z_ptr);
	endproperty
	a_read_addr: assert property (p_read_addr)
		else $error("read address wrong");
	// vector is caught on the third edge after release: wait three clean cycles
	property p_vector;
		$past(reset_n) && $past(reset_n, 2) && $past(reset_n, 3)
			|-> reset_vector == (boot_reset_fuse ? APP_RESET_ADDR :
			BOOT_RESET_ADDR);
	endproperty
	a_vector: assert property (p_vector)
		else $error("reset vector wrong");
endmodule

// ### flash_spm_pkg.sv
// constants, field layouts and carrier types for the flash self-program
// control block; assumes a single 25 MHz cpu clock domain for all users
package flash_spm_pkg;

	// ==========================================================
	// register map and field positions
	localparam logic [7:0] CTRL_OFFSET     = 8'h00;
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam int         IRQ_EN_POS      = 7;
	localparam int         BUSY_POS        = 6;
	localparam int         RES_POS         = 5;
	localparam int         REENABLE_POS    = 4;
	localparam int         LOCK_SET_POS    = 3;
	localparam int         PAGE_WRITE_POS  = 2;
	localparam int         PAGE_ERASE_POS  = 1;
	localparam int         STORE_EN_POS    = 0;

	// ==========================================================
	// idle value and legal arming patterns of the low five control bits
	localparam logic [4:0] PAT_NONE        = 5'h00;
	localparam logic [4:0] PAT_REENABLE    = 5'h11;
	localparam logic [4:0] PAT_LOCK        = 5'h09;
	localparam logic [4:0] PAT_WRITE       = 5'h05;
	localparam logic [4:0] PAT_ERASE       = 5'h03;
	localparam logic [4:0] PAT_LOAD        = 5'h01;

	// ==========================================================
	// instruction windows in cpu clocks, counted from the register write
	localparam logic [2:0] STORE_WIN_CLKS  = 3'h4;
	localparam logic [2:0] LOAD_WIN_CLKS   = 3'h3;
	localparam logic [2:0] LOAD_MIN_CNT    = STORE_WIN_CLKS - LOAD_WIN_CLKS;

	// ==========================================================
	// flash geometry and address split of the z pointer
	localparam int         WORD_BITS       = 6;
	localparam int         PAGE_WORDS      = 64;
	localparam int         PAGE_BITS       = 8;
	localparam int         WORD_LSB        = 1;
	localparam int         WORD_MSB        = 6;
	localparam int         PAGE_LSB        = 7;
	localparam int         PAGE_MSB        = 14;
	localparam logic [7:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 8'hE0;

	// ==========================================================
	// reset vectors, readback selectors and data constants
	localparam logic [15:0] APP_RESET_ADDR  = 16'h0000;
	localparam logic [15:0] BOOT_RESET_ADDR = 16'h7000;
	localparam logic [15:0] Z_FUSE_LOW      = 16'h0000;
	localparam logic [15:0] Z_LOCK          = 16'h0001;
	localparam logic [15:0] Z_FUSE_HIGH     = 16'h0003;
	localparam logic [7:0]  LOCK_R0_MASK    = 8'h3C;
	localparam logic [15:0] ERASED_WORD     = 16'hFFFF;

	// ==========================================================
	// enumerations
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_ARMED = 3'h2,
		ST_BUSY  = 3'h4
	} seq_state_type;

	typedef enum logic [1:0] {
		CMD_NONE  = 2'h0,
		CMD_ERASE = 2'h1,
		CMD_WRITE = 2'h2,
		CMD_LOCK  = 2'h3
	} flash_op_type;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_type;

	typedef struct packed {
		logic                 valid;
		flash_op_type         op;
		logic [PAGE_BITS-1:0] page;
		logic [7:0]           lock_data;
	} flash_cmd_type;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} read_req_type;

endpackage

// ### test_flash_self_program_control.sv
// self-checking bench for the flash self-program sequencer
// assumes the package, checker and array model are compiled first
`timescale 1ns/1ns

module test_flash_self_program_control;
	import flash_spm_pkg::*;
	logic ref_clk = 1'b0, reset_n = 1'b0, spm_exec = 1'b0, lpm_exec = 1'b0;
	logic global_irq_enable = 1'b1, eeprom_busy = 1'b0, boot_reset_fuse = 1'b1;
	logic [15:0] z_ptr = 16'h0000, r1r0_data = 16'h0000;
	logic [7:0] fuse_low = 8'hA5, fuse_high = 8'h5A, lock_bits = 8'hF3;
	logic [7:0] done_delay = 8'h14, rv, reg_rd_data, lpm_data;
	logic [5:0] buf_rd_index = 6'h00;
	logic [15:0] buf_rd_data, reset_vector;
	logic flash_done, lpm_valid, cpu_halt, section_read_block, ready_irq;
	reg_req_type reg_req = '0;
	flash_cmd_type flash_cmd;
	read_req_type read_req;
	int mismatches = 0, cmp_count = 0, cycles = 0;

	flash_self_program_control flash_self_program_control_inst (.ref_clk, .reset_n,
		.reg_req, .reg_rd_data, .spm_exec, .lpm_exec, .z_ptr, .r1r0_data,
		.global_irq_enable, .eeprom_busy, .boot_reset_fuse, .fuse_low, .fuse_high,
		.lock_bits, .flash_cmd, .flash_done, .buf_rd_index, .buf_rd_data, .read_req,
		.lpm_valid, .lpm_data, .reset_vector, .cpu_halt, .section_read_block, .ready_irq);
	flash_array_model flash_array_model_inst (.ref_clk, .reset_n, .flash_cmd,
		.done_delay, .flash_done);

	// ==========================================================
	// clock, hang guard and verdict
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_sim();
		end
	end
	task end_sim;
		if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch t=%0t %s", $time, what);
		end
	endtask

	// ==========================================================
	// bus and instruction drivers; each request lasts one clock
	task wr(input logic [7:0] d);
		@(posedge ref_clk) reg_req <= '{8'h00, d, 1'b1, 1'b0};
		@(posedge ref_clk) reg_req.wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge ref_clk) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk) reg_req.rd <= 1'b0;
		#1 rv = reg_rd_data;
	endtask
	task exec(input logic is_spm, input logic [15:0] z, input logic [15:0] d);
		@(posedge ref_clk) {spm_exec, lpm_exec} <= {is_spm, !is_spm};
		z_ptr <= z;
		r1r0_data <= d;
		@(posedge ref_clk) {spm_exec, lpm_exec} <= 2'b00;
		#1;
	endtask
	task bufchk(input logic [5:0] i, input logic [15:0] exp);
		@(posedge ref_clk) buf_rd_index <= i;
		repeat (2) @(posedge ref_clk);
		#1 chk(buf_rd_data, exp, "buffer word");
	endtask
	task wait_done;
		for (int i = 0; i < 100; i++) begin
			@(posedge ref_clk) #1;
			if (flash_done === 1'b1) break;
		end
		@(posedge ref_clk) #1;
	endtask

	// ==========================================================
	// scenarios
	task t_regs;
		rd(8'h00); chk(rv, CTRL_RESET, "ctrl reset");
		chk(reset_vector, APP_RESET_ADDR, "app vector");
		wr(8'hFF); rd(8'h00); chk(rv, 8'h80, "bad pattern");
		chk(ready_irq, 1'b1, "ready request");
		rd(8'h01); chk(rv, 8'h00, "unmapped");
		// armed store-enable must silence the ready request
		wr(8'h81);
		@(posedge ref_clk) #1;
		chk(ready_irq, 1'b0, "ready while armed");
		wr(8'h00);
	endtask
	task t_load;
		wr(8'h01); exec(1'b1, 16'h000B, 16'h1234);
		wr(8'h01); exec(1'b1, 16'h0004, 16'h5678);
		wr(8'h01); exec(1'b1, 16'h000A, 16'h9999);
		rd(8'h00); chk(rv, 8'h00, "store clears");
		wr(8'h01); repeat (5) @(posedge ref_clk);
		exec(1'b1, 16'h000E, 16'h4321);
		bufchk(6'h05, 16'h1234);
		bufchk(6'h02, 16'h5678);
		bufchk(6'h07, ERASED_WORD);
	endtask
	task t_erase;
		wr(8'h03); exec(1'b1, 16'h0800, 16'hFFFF);
		chk(flash_cmd.valid, 1'b1, "erase issued");
		chk(flash_cmd.op, CMD_ERASE, "erase op");
		chk(section_read_block, 1'b1, "busy set");
		chk(cpu_halt, 1'b0, "rww no halt");
		@(posedge ref_clk) z_ptr <= 16'h7F80;
		wr(8'h11); rd(8'h00); chk(rv, 8'h43, "held during op");
		chk(flash_cmd.page, 8'h10, "page latched");
		exec(1'b0, 16'h0100, 16'h0000); chk(read_req.valid, 1'b0, "rww blocked");
		wait_done(); rd(8'h00); chk(rv, 8'h40, "busy stays");
		// reenable store clears busy; then a second erase sets it again
		wr(8'h11);
		exec(1'b1, 16'h0000, 16'h0000);
		rd(8'h00);
		chk(rv, 8'h00, "reenable clears busy");
		wr(8'h03);
		exec(1'b1, 16'h0800, 16'hFFFF);
		wait_done();
		wr(8'h01); exec(1'b1, 16'h0002, 16'h0BAD);
		rd(8'h00); chk(rv, 8'h00, "load clears busy");
	endtask
	task t_write;
		@(posedge ref_clk) done_delay <= 8'h02;
		wr(8'h03); exec(1'b1, 16'h7000, 16'hFFFF); chk(cpu_halt, 1'b1, "halt");
		wait_done(); chk(cpu_halt, 1'b0, "halt released");
		wr(8'h11); bufchk(6'h01, ERASED_WORD);
		wr(8'h01); exec(1'b1, 16'h000A, 16'hABCD);
		wr(8'h05); exec(1'b1, 16'h7000, 16'h0000);
		chk(flash_cmd.op, CMD_WRITE, "write op");
		chk(flash_cmd.page, 8'hE0, "write page");
		wait_done(); bufchk(6'h05, ERASED_WORD);
	endtask
	task t_readback;
		logic [15:0] z;
		logic [7:0]  exp_rb;
		for (int i = 0; i < 3; i++) begin
			z      = (i == 0) ? Z_LOCK : (i == 1) ? Z_FUSE_LOW : Z_FUSE_HIGH;
			exp_rb = (i == 0) ? lock_bits : (i == 1) ? fuse_low : fuse_high;
			wr(8'h09);
			exec(1'b0, z, 16'h0000);
			chk(lpm_valid, 1'b1, "readback valid");
			chk(lpm_data, exp_rb, "readback");
		end
		// load in the fourth cycle is past the readback window
		wr(8'h09);
		repeat (2) @(posedge ref_clk);
		exec(1'b0, Z_LOCK, 16'h0000);
		chk(lpm_valid, 1'b0, "late readback refused");
		exec(1'b0, 16'h0123, 16'h0000);
		chk(read_req.valid, 1'b1, "byte read issued");
		chk(read_req.addr, 16'h0123, "byte read");
		// eeprom write starts while armed: readback and reads dropped
		wr(8'h09);
		@(posedge ref_clk) eeprom_busy <= 1'b1;
		exec(1'b0, Z_LOCK, 16'h0000);
		chk(lpm_valid, 1'b0, "eeprom blocks readback");
		chk(read_req.valid, 1'b0, "eeprom blocks read");
		wr(8'h09);
		rd(8'h00);
		chk(rv, 8'h00, "eeprom blocks arm");
		@(posedge ref_clk) eeprom_busy <= 1'b0;
	endtask
	task t_lock;
		wr(8'h09); exec(1'b1, 16'h5555, 16'h77C3);
		chk(flash_cmd.op, CMD_LOCK, "lock op");
		// r0 bits 5..2 clear: those lock bits programmed, others kept
		chk(flash_cmd.lock_data, 8'hC3, "lock data");
		rd(8'h00); chk(rv, 8'h00, "lock clears");
	endtask

	// ==========================================================
	// main sequence, ending in a second reset with the boot fuse low
	initial begin
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		t_regs();
		t_load();
		t_erase();
		t_write();
		t_readback();
		t_lock();
		@(posedge ref_clk) reset_n <= 1'b0;
		boot_reset_fuse <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
		#1 chk(reset_vector, BOOT_RESET_ADDR, "boot vector");
		end_sim();
	end
endmodule

bind flash_self_program_control flash_self_program_control_assertions
	flash_self_program_control_assertions_inst (.ref_clk, .reset_n, .reg_req,
	.reg_rd_data, .spm_exec, .lpm_exec, .z_ptr, .eeprom_busy, .boot_reset_fuse,
	.flash_cmd, .flash_done, .read_req, .lpm_valid, .cpu_halt, .reset_vector);
